// ### design/dtc_top.v
// Dynamic minimum fan-start temperature control bank with APB slave.
// Holds control registers 1 and 2, the three operating points that the
// alert pin can capture into, a lock register and a status register.
// Assumes temperatures and conversion strobes come from logic on pclk,
// and that the alert pin is asynchronous and active low.
// Bus answer: one wait state, so pready is high in the second access
// cycle and a write lands at the edge that ends that cycle.
// The lock guards both control registers and the three operating points
// against software only; alert capture still loads a locked point.
// Every output but the APB answer is a registered copy, one cycle behind the state.
// Bits 0 and 1 of control 1 and all of control 2 are stored only.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "dtc_defines.vh"
module dtc_top #(
    parameter ADDR_W = 12,
    parameter TEMP_W = 8
) (
    input  wire              pclk,                     // APB clock, 200 MHz
    input  wire              presetn,                  // Async reset, active low
    input  wire              psel,                     // APB select
    input  wire              penable,                  // APB access phase
    input  wire              pwrite,                   // APB direction, 1 = write
    input  wire [ADDR_W-1:0] paddr,                    // APB byte address
    input  wire [31:0]       pwdata,                   // APB write data
    input  wire [3:0]        pstrb,                    // APB byte strobes
    output reg  [31:0]       prdata,                   // APB read data
    output reg               pready,                   // APB ready
    output reg               pslverr,                  // APB error
    input  wire              thermal_alert_pin_n,      // Alert pin sense, low = asserted
    input  wire [TEMP_W-1:0] remote1_temp,             // Remote 1 present temperature
    input  wire [TEMP_W-1:0] local_temp,               // Local present temperature
    input  wire [TEMP_W-1:0] remote2_temp,             // Remote 2 present temperature
    input  wire              remote1_conv_done,        // Remote 1 new result strobe
    input  wire              local_conv_done,          // Local new result strobe
    input  wire              remote2_conv_done,        // Remote 2 new result strobe
    output reg  [TEMP_W-1:0] remote1_op_point,         // Remote 1 operating point
    output reg  [TEMP_W-1:0] local_op_point,           // Local operating point
    output reg  [TEMP_W-1:0] remote2_op_point,         // Remote 2 operating point
    output reg               remote1_dynamic_enable,   // Dynamic adjust remote 1
    output reg               local_dynamic_enable,     // Dynamic adjust local
    output reg               remote2_dynamic_enable,   // Dynamic adjust remote 2
    output reg  [7:0]        dyn_ctrl1_out,            // Control register 1 contents
    output reg  [7:0]        dyn_ctrl2_out,            // Control register 2 contents
    output reg               config_locked             // Lock state
);

    // Register state
    reg  [7:0]        dyn_ctrl1_reg;
    reg  [7:0]        dyn_ctrl2_reg;
    reg  [TEMP_W-1:0] op_r1_reg;
    reg  [TEMP_W-1:0] op_lc_reg;
    reg  [TEMP_W-1:0] op_r2_reg;
    reg               lock_reg;
    reg               alert_prev_reg;

    // Bus handshake state
    reg               ready_reg;
    reg  [31:0]       rdata_next;
    reg               err_next;

    // Decoded bus, alert and capture signals
    wire              alert_level;
    wire [7:0]        idx;
    wire              access_ph;
    wire              wr_commit;
    wire              lane0;
    wire              alert_on;
    wire              alert_rise;
    wire              hit_r1;
    wire              hit_lc;
    wire              hit_r2;
    wire              hit_c1;
    wire              hit_c2;
    wire              hit_lk;
    wire              hit_st;
    wire              mapped;
    wire              cap_r1;
    wire              cap_lc;
    wire              cap_r2;

    // Per-register software write enables, lock and strobe already applied
    wire              we_r1;
    wire              we_lc;
    wire              we_r2;
    wire              we_c1;
    wire              we_c2;
    wire              we_lk;

    // Alert pin crosses into pclk through three stages and a filter
    dtc_pin_sync #(
        .RESET_LEVEL (1'b1)
    ) u_alert_sync (
        .clk       (pclk),
        .rst_n     (presetn),
        .pin_in    (thermal_alert_pin_n),
        .level_out (alert_level)
    );

    // Next operating point: hardware capture first, then software write
    // A capture must not be lost to a write that happens to land with it
    function [TEMP_W-1:0] op_next;
        input [TEMP_W-1:0] cur;
        input              capture;
        input [TEMP_W-1:0] temp;
        input              sw_write;
        input [TEMP_W-1:0] wdata;
        begin
            if (capture) begin
                op_next = temp;
            end else if (sw_write) begin
                op_next = wdata;
            end else begin
                op_next = cur;
            end
        end
    endfunction

    // Capture trigger: first edge of assertion or each new result while held
    function cap_trig;
        input enable_bit;
        input rise;
        input held;
        input conv_done;
        begin
            cap_trig = enable_bit & (rise | (held & conv_done));
        end
    endfunction

    // Write enable for one register: committed, mapped, lane 0 and unlocked
    function wr_ok;
        input hit;
        input commit;
        input in_map;
        input lane;
        input locked;
        begin
            wr_ok = hit & commit & in_map & lane & ~locked;
        end
    endfunction

    // Byte address to register index; low two bits ignored
    assign idx       = paddr[9:2];
    assign access_ph = psel & penable;
    assign wr_commit = access_ph & ready_reg & pwrite;
    assign lane0     = pstrb[0];

    assign hit_r1 = (idx == `DTC_IDX_OP_REMOTE1);
    assign hit_lc = (idx == `DTC_IDX_OP_LOCAL);
    assign hit_r2 = (idx == `DTC_IDX_OP_REMOTE2);
    assign hit_c1 = (idx == `DTC_IDX_DYN_CTRL1);
    assign hit_c2 = (idx == `DTC_IDX_DYN_CTRL2);
    assign hit_lk = (idx == `DTC_IDX_LOCK);
    assign hit_st = (idx == `DTC_IDX_STATUS);
    assign mapped = (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}})
                  & (hit_r1 | hit_lc | hit_r2 | hit_c1 | hit_c2 | hit_lk | hit_st);

    // A locked register swallows the write; pslverr reports it separately
    assign we_r1 = wr_ok(hit_r1, wr_commit, mapped, lane0, lock_reg);
    assign we_lc = wr_ok(hit_lc, wr_commit, mapped, lane0, lock_reg);
    assign we_r2 = wr_ok(hit_r2, wr_commit, mapped, lane0, lock_reg);
    assign we_c1 = wr_ok(hit_c1, wr_commit, mapped, lane0, lock_reg);
    assign we_c2 = wr_ok(hit_c2, wr_commit, mapped, lane0, lock_reg);
    assign we_lk = wr_ok(hit_lk, wr_commit, mapped, lane0, lock_reg);

    // Alert is active low on the pin
    assign alert_on   = ~alert_level;
    assign alert_rise = alert_on & ~alert_prev_reg;

    // Per-channel capture; a clear capture bit masks the pin entirely
    // A held pin reloads only on a new conversion result, not every cycle
    assign cap_r1 = cap_trig(dyn_ctrl1_reg[`DTC_BIT_R1_CAPTURE], alert_rise,
                             alert_on, remote1_conv_done);
    assign cap_lc = cap_trig(dyn_ctrl1_reg[`DTC_BIT_LC_CAPTURE], alert_rise,
                             alert_on, local_conv_done);
    assign cap_r2 = cap_trig(dyn_ctrl1_reg[`DTC_BIT_R2_CAPTURE], alert_rise,
                             alert_on, remote2_conv_done);

    // Edge history of the filtered alert
    // Starts deasserted like the synchroniser, so reset makes no false edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert_prev_reg <= 1'b0;
        end else begin
            alert_prev_reg <= alert_on;
        end
    end

    // Lock is set by software and only reset clears it
    // A second lock write is accepted but changes nothing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_reg <= 1'b0;
        end else if (we_lk) begin
            lock_reg <= pwdata[`DTC_BIT_LOCK];
        end
    end

    // Control registers; writes after lock are dropped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dyn_ctrl1_reg <= `DTC_RST_DYN_CTRL1;
            dyn_ctrl2_reg <= `DTC_RST_DYN_CTRL2;
        end else begin
            // Enables already carry the lock, so a locked write changes nothing
            if (we_c1) begin
                dyn_ctrl1_reg <= pwdata[7:0];
            end
            if (we_c2) begin
                dyn_ctrl2_reg <= pwdata[7:0];
            end
        end
    end

    // Operating points; capture beats a write landing in the same cycle
    // Capture ignores the lock: only software writes are guarded
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_r1_reg <= `DTC_RST_OP_POINT;
            op_lc_reg <= `DTC_RST_OP_POINT;
            op_r2_reg <= `DTC_RST_OP_POINT;
        end else begin
            op_r1_reg <= op_next(op_r1_reg, cap_r1, remote1_temp,
                                 we_r1,
                                 pwdata[TEMP_W-1:0]);
            op_lc_reg <= op_next(op_lc_reg, cap_lc, local_temp,
                                 we_lc,
                                 pwdata[TEMP_W-1:0]);
            op_r2_reg <= op_next(op_r2_reg, cap_r2, remote2_temp,
                                 we_r2,
                                 pwdata[TEMP_W-1:0]);
        end
    end

    // Error decode for the access in progress
    always @* begin
        err_next = 1'b0;
        if (!mapped) begin
            err_next = 1'b1;
        end else if (pwrite) begin
            // Locked writes and writes to status are refused; a second lock
            // write is harmless and so answers without error
            err_next = hit_st | (lock_reg & ~hit_lk);
        end
    end

    // Read mux; unmapped reads and all writes return zero
    always @* begin
        rdata_next = 32'h0000_0000;
        if (mapped && !pwrite) begin
            case (1'b1)
                hit_r1: begin
                    rdata_next[TEMP_W-1:0] = op_r1_reg;
                end
                hit_lc: begin
                    rdata_next[TEMP_W-1:0] = op_lc_reg;
                end
                hit_r2: begin
                    rdata_next[TEMP_W-1:0] = op_r2_reg;
                end
                hit_c1: begin
                    rdata_next[7:0] = dyn_ctrl1_reg;
                end
                hit_c2: begin
                    rdata_next[7:0] = dyn_ctrl2_reg;
                end
                hit_lk: begin
                    rdata_next[`DTC_BIT_LOCK] = lock_reg;
                end
                hit_st: begin
                    rdata_next[`DTC_BIT_ST_ALERT]  = alert_on;
                    rdata_next[`DTC_BIT_ST_LOCKED] = lock_reg;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    // One wait state: ready rises in the second access cycle so the
    // read mux and outputs are all registered, at a cost of one cycle
    // ready_reg is the internal twin of pready, read by the handshake
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
            pready    <= 1'b0;
        end else if (access_ph && !ready_reg) begin
            ready_reg <= 1'b1;
            pready    <= 1'b1;
        end else begin
            ready_reg <= 1'b0;
            pready    <= 1'b0;
        end
    end

    // Answer data and error stand only in the ready cycle, zero otherwise,
    // so a master that samples late sees nothing stale
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access_ph && !ready_reg) begin
            prdata  <= rdata_next;
            pslverr <= err_next;
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Operating point copies for the fan-control loop downstream
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote1_op_point <= `DTC_RST_OP_POINT;
            local_op_point   <= `DTC_RST_OP_POINT;
            remote2_op_point <= `DTC_RST_OP_POINT;
        end else begin
            remote1_op_point <= op_r1_reg;
            local_op_point   <= op_lc_reg;
            remote2_op_point <= op_r2_reg;
        end
    end

    // Control copies; the loop acts only on the three enables, the rest
    // is shown so that a monitor needs no bus access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote1_dynamic_enable <= 1'b0;
            local_dynamic_enable   <= 1'b0;
            remote2_dynamic_enable <= 1'b0;
            dyn_ctrl1_out          <= `DTC_RST_DYN_CTRL1;
            dyn_ctrl2_out          <= `DTC_RST_DYN_CTRL2;
            config_locked          <= 1'b0;
        end else begin
            remote1_dynamic_enable <= dyn_ctrl1_reg[`DTC_BIT_R1_DYN];
            local_dynamic_enable   <= dyn_ctrl1_reg[`DTC_BIT_LC_DYN];
            remote2_dynamic_enable <= dyn_ctrl1_reg[`DTC_BIT_R2_DYN];
            dyn_ctrl1_out          <= dyn_ctrl1_reg;
            dyn_ctrl2_out          <= dyn_ctrl2_reg;
            config_locked          <= lock_reg;
        end
    end

endmodule

// ### design/dtc_defines.vh
// Register map, field positions, reset values and timing for the
// dynamic minimum fan-start temperature control bank.
// Assumes the including file is plain Verilog-2005 with one clock.
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// Register indexes; byte address is four times the index
`define DTC_IDX_OP_REMOTE1   8'h33
`define DTC_IDX_OP_LOCAL     8'h34
`define DTC_IDX_OP_REMOTE2   8'h35
`define DTC_IDX_DYN_CTRL1    8'h36
`define DTC_IDX_DYN_CTRL2    8'h37
`define DTC_IDX_LOCK         8'h3E
`define DTC_IDX_STATUS       8'h3F

// Reset values
`define DTC_RST_OP_POINT     8'h64
`define DTC_RST_DYN_CTRL1    8'h00
`define DTC_RST_DYN_CTRL2    8'h00

// Control register 1 field positions
`define DTC_BIT_R1_CAPTURE   3'd2
`define DTC_BIT_LC_CAPTURE   3'd3
`define DTC_BIT_R2_CAPTURE   3'd4
`define DTC_BIT_R1_DYN       3'd5
`define DTC_BIT_LC_DYN       3'd6
`define DTC_BIT_R2_DYN       3'd7

// Lock and status field positions
`define DTC_BIT_LOCK         3'd0
`define DTC_BIT_ST_ALERT     3'd0
`define DTC_BIT_ST_LOCKED    3'd1

// Pin synchroniser depth
`define DTC_SYNC_STAGES      3

`endif

// ### design/dtc_pin_sync.v
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to clk; output is a clean level.
`timescale 1ns/10ps
module dtc_pin_sync #(
    parameter RESET_LEVEL = 1'b1
) (
    input  wire clk,      // System clock
    input  wire rst_n,    // Asynchronous reset, active low
    input  wire pin_in,   // Raw pin level
    output reg  level_out // Filtered level
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // Chain; only s2 reads s1 so metastability stays in stage one
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= RESET_LEVEL;
            s2_reg <= RESET_LEVEL;
            s3_reg <= RESET_LEVEL;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Level moves only once stages two and three agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_out <= RESET_LEVEL;
        end else if (s2_reg == s3_reg) begin
            level_out <= s3_reg;
        end
    end
endmodule

// ### bench/dtc_top_properties.sv
// Concurrent checks on the APB side and control outputs of dtc_top.
// Assumes the single clock pclk and the asynchronous active-low presetn.
`timescale 1ns/10ps
module dtc_top_properties #(
    parameter ADDR_W = 12,
    parameter TEMP_W = 8
) (
    input wire              pclk,                   // Clock
    input wire              presetn,                // Reset, active low
    input wire              psel,                   // APB select
    input wire              penable,                // APB access phase
    input wire              pwrite,                 // APB direction
    input wire [ADDR_W-1:0] paddr,                  // APB address
    input wire [31:0]       pwdata,                 // APB write data
    input wire [3:0]        pstrb,                  // APB strobes
    input wire [31:0]       prdata,                 // APB read data
    input wire              pready,                 // APB ready
    input wire              pslverr,                // APB error
    input wire              remote1_dynamic_enable, // Dynamic adjust remote 1
    input wire              local_dynamic_enable,   // Dynamic adjust local
    input wire              remote2_dynamic_enable, // Dynamic adjust remote 2
    input wire [7:0]        dyn_ctrl1_out,          // Control register 1
    input wire [7:0]        dyn_ctrl2_out,          // Control register 2
    input wire              config_locked           // Lock state
);
    // Everything here lives on pclk and is silenced during reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus timing: one wait state, one-cycle answer, never unasked
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    a_one_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access phase");
    a_idle_data: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside the answer cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // Accepted control write shows on the port two edges later
    a_ctrl_write: assert property (
        pready && pwrite && paddr == 12'h0D8 && pstrb[0] && !pslverr
        |-> ##2 dyn_ctrl1_out == $past(pwdata[7:0], 2))
        else $error("control write not stored");
    a_lock_sticky: assert property (config_locked |=> config_locked)
        else $error("lock dropped without reset");
    a_locked_reject: assert property (
        config_locked && pready && pwrite && paddr[9:2] != 8'h3E |-> pslverr)
        else $error("write accepted while locked");
    a_locked_stable: assert property (
        config_locked |=> $stable({dyn_ctrl1_out, dyn_ctrl2_out}))
        else $error("control changed while locked");
    a_enables_track: assert property (
        {remote2_dynamic_enable, local_dynamic_enable, remote1_dynamic_enable}
        == dyn_ctrl1_out[7:5])
        else $error("dynamic enables differ from control bits");
endmodule

bind dtc_top dtc_top_properties #(.ADDR_W(ADDR_W), .TEMP_W(TEMP_W)) dtc_top_properties_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .remote1_dynamic_enable(remote1_dynamic_enable),
    .local_dynamic_enable(local_dynamic_enable), .remote2_dynamic_enable(remote2_dynamic_enable),
    .dyn_ctrl1_out(dyn_ctrl1_out), .dyn_ctrl2_out(dyn_ctrl2_out), .config_locked(config_locked));

// ### bench/dtc_top_bench.sv
// Self-checking bench for dtc_top: APB master tasks, alert pin and sensor stimulus.
// Assumes the design files are compiled first; runs at 200 MHz.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("Error t=%0t got %h expected %h", $time, (g), (e)); end end
module dtc_top_bench;
    logic        pclk, presetn, psel, penable, pwrite, pin_n, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  tmp [3];
    logic [2:0]  conv;
    wire  [31:0] prdata;
    wire         pready, pslverr, locked;
    wire  [7:0]  op [3];
    wire  [2:0]  dyn_en;
    wire  [7:0]  ctl1, ctl2;
    int          err_total, n_compared;

    dtc_top dtc_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .thermal_alert_pin_n(pin_n), .remote1_temp(tmp[0]),
        .local_temp(tmp[1]), .remote2_temp(tmp[2]), .remote1_conv_done(conv[0]),
        .local_conv_done(conv[1]), .remote2_conv_done(conv[2]), .remote1_op_point(op[0]),
        .local_op_point(op[1]), .remote2_op_point(op[2]), .remote1_dynamic_enable(dyn_en[0]),
        .local_dynamic_enable(dyn_en[1]), .remote2_dynamic_enable(dyn_en[2]),
        .dyn_ctrl1_out(ctl1), .dyn_ctrl2_out(ctl2), .config_locked(locked));

    // Free-running 5 ns clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            test_done();
        end
    endtask

    // No completion flag on capture, so poll the port under a bound
    task automatic wait_op(input int i, input logic [7:0] e);
        for (int n = 0; n < 20 && op[i] !== e; n++) @(posedge pclk);
        `CHK(op[i], e)
    endtask

    task t_reset;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'h0CC + 12'(4 * i), 32'h0);
            `CHK(rd[7:0], (i < 3) ? 8'h64 : 8'h00)
        end
        `CHK({op[0], op[1], op[2]}, {3{8'h64}})
        `CHK({ctl1, ctl2, dyn_en, locked}, 20'h0)
    endtask

    // Walk a one through control 1; enables and read-back must follow
    task t_regs;
        logic [7:0] v;
        for (int k = 0; k < 8; k++) begin
            v = 8'h01 << k;
            apb(1'b1, 12'h0D8, {24'h0, v});
            apb(1'b0, 12'h0D8, 32'h0);
            `CHK(rd, {24'h0, v})
            `CHK(dyn_en, v[7:5])
            `CHK(ctl1, v)
        end
        apb(1'b0, 12'h100, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        pstrb <= 4'h0;
        apb(1'b1, 12'h0DC, 32'h55);
        pstrb <= 4'h1;
        apb(1'b0, 12'h0DC, 32'h0);
        `CHK(rd[7:0], 8'h00)
        apb(1'b1, 12'h0DC, 32'hA5);
        apb(1'b0, 12'h0DC, 32'h0);
        `CHK({rd[7:0], ctl2}, {8'hA5, 8'hA5})
    endtask

    // Only channel i may capture; the others keep their programmed points
    task automatic t_capture(input int i);
        for (int j = 0; j < 3; j++) apb(1'b1, 12'h0CC + 12'(4 * j), 32'h20 + j);
        apb(1'b1, 12'h0D8, 32'h04 << i);
        pin_n <= 1'b0;
        wait_op(i, tmp[i]);
        for (int j = 0; j < 3; j++) tmp[j] <= tmp[j] + 8'h01;
        conv <= 3'b111;
        @(posedge pclk);
        conv <= 3'b000;
        wait_op(i, tmp[i]);
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK(rd[1:0], 2'b01)
        for (int j = 0; j < 3; j++) if (j != i) `CHK(op[j], 8'h20 + 8'(j))
        pin_n <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    task t_lock;
        apb(1'b1, 12'h0D8, 32'hA3);
        apb(1'b1, 12'h0F8, 32'h1);
        `CHK(er, 1'b0)
        apb(1'b1, 12'h0D8, 32'h00);
        `CHK({er, locked, ctl1}, {2'b11, 8'hA3})
        apb(1'b0, 12'h0D8, 32'h0);
        `CHK(rd[7:0], 8'hA3)
        apb(1'b1, 12'h0CC, 32'h77);
        `CHK(er, 1'b1)
        apb(1'b0, 12'h0CC, 32'h0);
        `CHK(rd[7:0], 8'h20)
        apb(1'b1, 12'h0F8, 32'h0);
        `CHK({er, locked}, 2'b01)
        apb(1'b1, 12'h0FC, 32'h3);
        `CHK(er, 1'b1)
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK(rd[1:0], 2'b10)
    endtask

    // Inputs settle at time zero, reset holds for 8 cycles
    initial begin
        err_total = 0;
        n_compared = 0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h1;
        pin_n = 1'b1;
        conv = 3'b000;
        presetn = 1'b0;
        tmp[0] = 8'h40;
        tmp[1] = 8'h50;
        tmp[2] = 8'h60;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        for (int i = 0; i < 3; i++) t_capture(i);
        t_lock();
        test_done();
    end
endmodule
